// File: shared/alu_slice_map.svh
`ifndef ALU_SLICE_MAP_SVH
`define ALU_SLICE_MAP_SVH
// direction-load operand values
`define DIR_SEL_PORT_A 7'h05
`define DIR_SEL_PORT_B 7'h06
`define DIR_SEL_PORT_C 7'h07
// reset values
`define WORK_RESET      8'h00
`define DIR_RESET       8'hff
`define WDT_RESET       8'h00
`define PRESCALE_RESET  8'h00
// status bit positions inside status_out
`define STAT_CARRY  0
`define STAT_DIGIT  1
`define STAT_ZERO   2
`define STAT_PD_N   3
`define STAT_TO_N   4
// destination select values
`define DEST_WORK 1'b0
`define DEST_FILE 1'b1
`endif

// File: shared/alu_slice_pkg.sv
package alu_slice_pkg;
  // instruction codes from the decoder, one-hot except op_none which is all zeros
  typedef enum logic [8:0] {
    op_none                = 9'h000,
    rotate_right_carry_op  = 9'h001,
    sub_from_literal_op    = 9'h002,
    sub_work_from_reg_op   = 9'h004,
    sub_with_borrow_op     = 9'h008,
    nibble_exchange_op     = 9'h010,
    xor_literal_op         = 9'h020,
    xor_register_op        = 9'h040,
    direction_load_op      = 9'h080,
    halt_op                = 9'h100
  } alu_op_t;
  // core run state, one-hot
  typedef enum logic [1:0] {
    st_run  = 2'b01,
    st_halt = 2'b10
  } core_state_t;
endpackage

// File: src/sub_unit.sv
`timescale 1ns/1ps
`include "alu_slice_map.svh"
// a - b - borrow_in with no-borrow flags for full byte and low nibble
module sub_unit #(
  parameter int WIDTH = 8
) (
  // operands
  input  wire logic [WIDTH-1:0] minuend,
  input  wire logic [WIDTH-1:0] subtrahend,
  input  wire logic             borrow_in,
  // results
  output logic      [WIDTH-1:0] diff,
  output logic                  no_borrow,
  output logic                  nibble_no_borrow
);
  logic [WIDTH:0] full_sum;
  logic [4:0]     low_sum;

  // add the inverted subtrahend; carry out set means no borrow
  always_comb begin
    full_sum         = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, ~borrow_in};
    low_sum          = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, ~borrow_in};
    diff             = full_sum[WIDTH-1:0];
    no_borrow        = full_sum[WIDTH];
    nibble_no_borrow = low_sum[4];
  end
endmodule

// File: src/alu_slice.sv
`timescale 1ns/1ps
`include "alu_slice_map.svh"
module alu_slice
  import alu_slice_pkg::*;
#(
  parameter int WIDTH    = 8,
  parameter int ADDR_W   = 7,
  parameter int WDT_W    = 8,
  parameter int PRESC_W  = 8
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // decoded instruction
  input  wire logic              op_valid,
  input  wire alu_op_t           op_code,
  input  wire logic [ADDR_W-1:0] file_addr,
  input  wire logic [WIDTH-1:0]  literal,
  input  wire logic              dest_sel,
  // file register array
  input  wire logic [WIDTH-1:0]  file_rdata,
  output logic                   file_we,
  output logic      [ADDR_W-1:0] file_waddr,
  output logic      [WIDTH-1:0]  file_wdata,
  // watchdog and wake
  input  wire logic              wdt_tick,
  input  wire logic              wake_event,
  // architectural state
  output logic      [WIDTH-1:0]  work_out,
  output logic      [4:0]        status_out,
  output logic      [WIDTH-1:0]  port_a_direction,
  output logic      [WIDTH-1:0]  port_b_direction,
  output logic      [WIDTH-1:0]  port_c_direction,
  output logic      [WDT_W-1:0]  watchdog_counter,
  output logic      [PRESC_W-1:0] watchdog_prescale,
  output logic                   halted,
  output logic                   osc_enable,
  output logic                   op_ready
);
  logic [WIDTH-1:0]   work_reg, work_next;
  logic               carry_reg, carry_next;
  logic               digit_carry_flag, digit_next;
  logic               zero_reg, zero_next;
  logic               powerdown_status_n, pd_next;
  logic               timeout_status_n, to_next;
  logic [WIDTH-1:0]   dir_a_reg, dir_a_next, dir_b_reg, dir_b_next, dir_c_reg, dir_c_next;
  logic [WDT_W-1:0]   wdt_reg, wdt_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  core_state_t        state_reg, state_next;
  logic               fwe_reg, fwe_next;
  logic [ADDR_W-1:0]  fwa_reg, fwa_next;
  logic [WIDTH-1:0]   fwd_reg, fwd_next;

  logic [WIDTH-1:0] sub_a, sub_b, sub_diff, result;
  logic             sub_bin, sub_c, sub_dc, exec;

  // route a result by the destination select
  function automatic logic to_file(input logic d);
    return d == `DEST_FILE;
  endfunction

  sub_unit #(.WIDTH(WIDTH)) u_sub (
    .minuend          (sub_a),
    .subtrahend       (sub_b),
    .borrow_in        (sub_bin),
    .diff             (sub_diff),
    .no_borrow        (sub_c),
    .nibble_no_borrow (sub_dc)
  );

  // instructions are accepted only while running
  assign exec     = op_valid && (state_reg == st_run);
  assign op_ready = (state_reg == st_run);

  // subtractor operand selection
  always_comb begin
    sub_a   = (op_code == sub_from_literal_op) ? literal : file_rdata;
    sub_b   = work_reg;
    sub_bin = (op_code == sub_with_borrow_op) ? ~carry_reg : 1'b0;
  end

  // instruction execution next state
  always_comb begin
    work_next  = work_reg;
    carry_next = carry_reg;
    digit_next = digit_carry_flag;
    zero_next  = zero_reg;
    pd_next    = powerdown_status_n;
    to_next    = timeout_status_n;
    dir_a_next = dir_a_reg;
    dir_b_next = dir_b_reg;
    dir_c_next = dir_c_reg;
    state_next = state_reg;
    fwe_next   = 1'b0;
    fwa_next   = fwa_reg;
    fwd_next   = fwd_reg;
    result     = work_reg;
    if (state_reg == st_halt) begin
      if (wake_event) begin
        state_next = st_run;
      end
    end else if (exec) begin
      case (op_code)
        rotate_right_carry_op: begin
          result     = {carry_reg, file_rdata[WIDTH-1:1]};
          carry_next = file_rdata[0];
        end
        sub_from_literal_op, sub_work_from_reg_op, sub_with_borrow_op: begin
          result     = sub_diff;
          carry_next = sub_c;
          digit_next = sub_dc;
          zero_next  = (sub_diff == '0);
        end
        nibble_exchange_op: begin
          result = {file_rdata[3:0], file_rdata[7:4]};
        end
        xor_literal_op: begin
          result    = work_reg ^ literal;
          zero_next = (result == '0);
        end
        xor_register_op: begin
          result    = work_reg ^ file_rdata;
          zero_next = (result == '0);
        end
        direction_load_op: begin
          // other operands are illegal and load nothing
          if (file_addr == `DIR_SEL_PORT_A) begin
            dir_a_next = work_reg;
          end else if (file_addr == `DIR_SEL_PORT_B) begin
            dir_b_next = work_reg;
          end else if (file_addr == `DIR_SEL_PORT_C) begin
            dir_c_next = work_reg;
          end
        end
        halt_op: begin
          pd_next    = 1'b0;
          to_next    = 1'b1;
          state_next = st_halt;
        end
        default: begin
        end
      endcase
      // literal forms always target working; file forms follow dest_sel
      case (op_code)
        sub_from_literal_op, xor_literal_op: begin
          work_next = result;
        end
        rotate_right_carry_op, sub_work_from_reg_op, sub_with_borrow_op,
        nibble_exchange_op, xor_register_op: begin
          if (to_file(dest_sel)) begin
            fwe_next = 1'b1;
            fwa_next = file_addr;
            fwd_next = result;
          end else begin
            work_next = result;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // watchdog counter and prescaler; halt clears both
  always_comb begin
    {wdt_next, presc_next} = {wdt_reg, presc_reg};
    if (exec && op_code == halt_op) begin
      wdt_next   = `WDT_RESET;
      presc_next = `PRESCALE_RESET;
    end else if (wdt_tick) begin
      presc_next = presc_reg + 1'b1;
      if (presc_reg == '1) begin
        wdt_next = wdt_reg + 1'b1;
      end
    end
  end

  // register every group of state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      work_reg           <= `WORK_RESET;
      carry_reg          <= 1'b0;
      digit_carry_flag   <= 1'b0;
      zero_reg           <= 1'b0;
      powerdown_status_n <= 1'b1;
      timeout_status_n   <= 1'b1;
      dir_a_reg          <= `DIR_RESET;
      dir_b_reg          <= `DIR_RESET;
      dir_c_reg          <= `DIR_RESET;
      wdt_reg            <= `WDT_RESET;
      presc_reg          <= `PRESCALE_RESET;
      state_reg          <= st_run;
      fwe_reg            <= 1'b0;
      fwa_reg            <= '0;
      fwd_reg            <= '0;
    end else begin
      work_reg           <= work_next;
      carry_reg          <= carry_next;
      digit_carry_flag   <= digit_next;
      zero_reg           <= zero_next;
      powerdown_status_n <= pd_next;
      timeout_status_n   <= to_next;
      dir_a_reg          <= dir_a_next;
      dir_b_reg          <= dir_b_next;
      dir_c_reg          <= dir_c_next;
      wdt_reg            <= wdt_next;
      presc_reg          <= presc_next;
      state_reg          <= state_next;
      fwe_reg            <= fwe_next;
      fwa_reg            <= fwa_next;
      fwd_reg            <= fwd_next;
    end
  end

  // outputs straight from flops
  always_comb begin
    status_out                = '0;
    status_out[`STAT_CARRY]   = carry_reg;
    status_out[`STAT_DIGIT]   = digit_carry_flag;
    status_out[`STAT_ZERO]    = zero_reg;
    status_out[`STAT_PD_N]    = powerdown_status_n;
    status_out[`STAT_TO_N]    = timeout_status_n;
  end
  assign work_out          = work_reg;
  assign port_a_direction  = dir_a_reg;
  assign port_b_direction  = dir_b_reg;
  assign port_c_direction  = dir_c_reg;
  assign watchdog_counter  = wdt_reg;
  assign watchdog_prescale = presc_reg;
  assign halted            = (state_reg == st_halt);
  assign osc_enable        = (state_reg == st_run);   // oscillator stopped while halted
  assign file_we           = fwe_reg;
  assign file_waddr        = fwa_reg;
  assign file_wdata        = fwd_reg;
endmodule

// File: dv/alu_slice_properties.sv
`timescale 1ns/1ps
// watches the slice ports only; attached by the bind below
module alu_slice_properties
  import alu_slice_pkg::*;
(
  // clock, reset and request
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       op_valid,
  input wire alu_op_t    op_code,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] literal,
  input wire logic       dest_sel,
  input wire logic [7:0] file_rdata,
  input wire logic       wake_event,
  // results
  input wire logic       file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] work_out,
  input wire logic [4:0] status_out,
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] watchdog_prescale,
  input wire logic       halted,
  input wire logic       osc_enable,
  input wire logic       op_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // an accepted request of one kind
  sequence go(alu_op_t o);
    op_valid && op_ready && op_code == o;
  endsequence
  AST_HALT_STATE: assert property (go(halt_op) |=> halted && !osc_enable && !op_ready)
    else $error("halt not entered");
  AST_HALT_FLAGS: assert property (go(halt_op) |=> status_out[4:3] == 2'b10
    && watchdog_counter == 8'h00 && watchdog_prescale == 8'h00) else $error("halt flags wrong");
  AST_HALT_HOLD: assert property (halted && !wake_event |=> halted)
    else $error("halt left without wake");
  AST_ROTATE: assert property (go(rotate_right_carry_op) ##0 !dest_sel |=>
    work_out == {$past(status_out[0]), $past(file_rdata[7:1])} && status_out[0] == $past(file_rdata[0]))
    else $error("rotate wrong");
  AST_SUB_CARRY: assert property (go(sub_from_literal_op) |=>
    status_out[0] == ($past(work_out) <= $past(literal))) else $error("subtract carry wrong");
  AST_XOR_LIT: assert property (go(xor_literal_op) |=> work_out == ($past(work_out) ^ $past(literal))
    && status_out[1:0] == $past(status_out[1:0])) else $error("xor literal wrong");
  AST_ZERO: assert property (go(xor_literal_op) |=> status_out[2] == (work_out == 8'h00))
    else $error("zero flag wrong");
  AST_SWAP_FLAGS: assert property (go(nibble_exchange_op) |=> $stable(status_out))
    else $error("swap touched status");
  AST_DEST_FILE: assert property (go(xor_register_op) ##0 dest_sel |=> file_we
    && file_waddr == $past(file_addr) && $stable(work_out)) else $error("file destination wrong");
  AST_DIR_A: assert property (go(direction_load_op) ##0 file_addr == 7'h05 |=>
    port_a_direction == $past(work_out)) else $error("direction load wrong");
endmodule
bind alu_slice alu_slice_properties chk (.*);

// File: dv/file_reg_model.sv
`timescale 1ns/1ps
// file register array: same-cycle read, write lands one cycle after the op
module file_reg_model (
  // core side
  input  wire logic       ref_clk,
  input  wire logic [6:0] file_addr,
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata,
  // read data
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [128];
  // seeded contents so no address reads unknown
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
  // bypass a write still in flight, as the decoder must
  assign file_rdata = (file_we && file_waddr == file_addr) ? file_wdata : mem[file_addr];
  always @(posedge ref_clk) if (file_we) mem[file_waddr] <= file_wdata;
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import alu_slice_pkg::*;
  logic ref_clk, reset_n, op_valid, dest_sel, file_we, wdt_tick, wake_event;
  logic halted, osc_enable, op_ready;
  alu_op_t op_code;
  logic [6:0] file_addr, file_waddr;
  logic [7:0] literal, file_rdata, file_wdata, work_out, watchdog_counter, watchdog_prescale;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  logic [4:0] status_out;
  int fails = 0, num_checks = 0;
  logic [7:0] w;
  logic c, dig, z;
  logic [23:0] dirs;
  alu_op_t ops[8] = '{rotate_right_carry_op, sub_from_literal_op, sub_work_from_reg_op,
    sub_with_borrow_op, nibble_exchange_op, xor_literal_op, xor_register_op, direction_load_op};

  alu_slice dut (.*);
  file_reg_model u_file (.*);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(string nm, logic [23:0] got, logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // {result, carry, digit carry}; subtracts use carry as no-borrow
  function automatic logic [9:0] predict(alu_op_t o, logic [7:0] f, k, w, logic c);
    logic [7:0] a;
    logic [8:0] s;
    logic [4:0] n;
    logic       cin;
    a = (o == sub_from_literal_op) ? k : f;
    cin = (o == sub_with_borrow_op) ? c : 1'b1;
    s = {1'b0, a} + {1'b0, ~w} + 9'(cin);
    n = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'(cin);
    case (o)
      rotate_right_carry_op: return {c, f[7:1], f[0], 1'b0};
      nibble_exchange_op:    return {f[3:0], f[7:4], 2'b00};
      xor_literal_op:        return {w ^ k, 2'b00};
      xor_register_op:       return {w ^ f, 2'b00};
      default:               return {s[7:0], s[8], n[4]};
    endcase
  endfunction

  // one op request, then compare the next cycle
  task automatic run_op(alu_op_t o, logic [6:0] a, logic [7:0] k, logic d);
    logic [9:0] p;
    logic       sub, wr, acc;
    @(posedge ref_clk);
    {op_valid, file_addr, literal, dest_sel, wdt_tick} <= {1'b1, a, k, d, 1'($urandom)};
    op_code <= o;
    #1;
    // a halted core refuses the op, so the model must not move either
    acc = op_ready;
    p = predict(o, file_rdata, k, w, c);
    sub = acc && (o inside {sub_from_literal_op, sub_work_from_reg_op, sub_with_borrow_op});
    wr = acc && d && !(o inside {sub_from_literal_op, xor_literal_op, direction_load_op, halt_op});
    if (acc && o == direction_load_op && a inside {[5:7]}) dirs[8*(7-a) +: 8] = w;
    if ((acc && o == rotate_right_carry_op) || sub) c = p[1];
    if (sub) dig = p[0];
    if (sub || (acc && o inside {xor_literal_op, xor_register_op})) z = (p[9:2] == 8'h00);
    if (acc && !wr && !(o inside {direction_load_op, halt_op})) w = p[9:2];
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
    check("work", 24'(work_out), 24'(w));
    check("flags", 24'(status_out[2:0]), 24'({z, dig, c}));
    // write address and data only mean something while the strobe is up
    check("file", 24'({file_we, wr ? {file_waddr, file_wdata} : 15'h0000}), 24'({wr, wr ? {a, p[9:2]} : 15'h0000}));
    check("dirs", {port_a_direction, port_b_direction, port_c_direction}, dirs);
  endtask

  initial begin
    #50000;
    fails++;
    close_out();
  end

  initial begin
    {reset_n, op_valid, dest_sel, wdt_tick, wake_event, file_addr, literal} = '0;
    op_code = op_none;
    {w, c, dig, z, dirs} = {8'h00, 3'b000, 24'hffffff};
    void'($urandom(32'h282a7821));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    check("reset", 24'({status_out, work_out}), 24'({5'b11000, 8'h00}));
    // every op except halt, both destinations, boundary literals
    foreach (ops[i]) for (int d = 0; d < 2; d++) run_op(ops[i], 7'h05, d ? 8'hff : 8'h00, 1'(d));
    run_op(direction_load_op, 7'h04, 8'h00, 1'b0);
    $display("corner test done");
    repeat (300) begin
      alu_op_t o;
      o = ops[$urandom_range(7)];
      run_op(o, (o == direction_load_op) ? 7'($urandom_range(7, 4)) : 7'($urandom), 8'($urandom), 1'($urandom));
    end
    $display("random test done");
    run_op(halt_op, 7'h00, 8'h00, 1'b0);
    check("halt", {halted, osc_enable, op_ready, status_out[4:3], watchdog_counter, watchdog_prescale, 3'b000}, 24'h900000);
    run_op(xor_literal_op, 7'h00, 8'h5a, 1'b0);
    @(posedge ref_clk);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    #1;
    check("wake", 24'({halted, op_ready}), 24'h000001);
    $display("halt test done");
    close_out();
  end
endmodule
